// ===== array_time_tick_generator.sv
/*
 * Array tick generator: divides the coarse reference down to the 48 ms
 * tick, drives it out as a short high pulse, marks every 125th tick as
 * second-aligned, measures its offset from the external 1 PPS and keeps
 * a 64-bit drift count. Assumes clk is the coarse reference and that
 * pps, align_req and drift_clear are asynchronous to it, while ce is synchronous.
 */
`timescale 1ns/1ns
module array_time_tick_generator #(
  parameter int unsigned TICK_DIV_P = tick_gen_pkg::TICK_DIV
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic pps,
  input wire logic align_req,
  input wire logic drift_clear,
  output logic tick_out,
  output logic tick_strobe,
  output logic second_tick,
  output logic aligned,
  output logic [tick_gen_pkg::OFFSET_W-1:0] second_offset,
  output logic offset_valid,
  output logic [tick_gen_pkg::DRIFT_W-1:0] drift_count
);
  import tick_gen_pkg::*;

  localparam logic [TICK_CNT_W-1:0] TICK_LAST = TICK_CNT_W'(TICK_DIV_P - 1);
  localparam logic [TICK_CNT_W-1:0] PULSE_END = TICK_CNT_W'(PULSE_CYC);
  localparam logic [SEC_CNT_W-1:0] SEC_LAST = SEC_CNT_W'(TICKS_PER_SEC - 1);

  logic [1:0] rst_sync;
  logic rst_int_n;
  logic [1:0] pps_sync;
  logic [1:0] align_sync;
  logic [1:0] clr_sync;
  logic pps_prev;
  logic pps_rise;
  logic [TICK_CNT_W-1:0] tick_cnt;
  logic [SEC_CNT_W-1:0] sec_cnt;
  logic wrap;
  logic align_armed;
  logic [OFFSET_W-1:0] offset_run;
  logic offset_open;

  // Reset is asserted at once and released two clock edges later.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_int_n = rst_sync[1];

  // Two-stage synchronisers; only stage one feeds stage two.
  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      pps_sync <= 2'h0;
      align_sync <= 2'h0;
      clr_sync <= 2'h0;
      pps_prev <= 1'b0;
    end else if (ce) begin
      pps_sync <= {pps_sync[0], pps};
      align_sync <= {align_sync[0], align_req};
      clr_sync <= {clr_sync[0], drift_clear};
      pps_prev <= pps_sync[1];
    end
  end
  assign pps_rise = pps_sync[1] & ~pps_prev;
  assign wrap = (tick_cnt == TICK_LAST);

  // Integer divider; a requested alignment restarts it on the next 1 PPS edge.
  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      tick_cnt <= '0;
      sec_cnt <= '0;
      align_armed <= 1'b0;
      aligned <= 1'b0;
    end else if (ce) begin
      if (align_armed && pps_rise) begin
        tick_cnt <= '0;
        sec_cnt <= '0;
        align_armed <= 1'b0;
        aligned <= 1'b1;
      end else begin
        if (align_sync[1]) begin
          align_armed <= 1'b1;
        end
        if (wrap) begin
          tick_cnt <= '0;
          sec_cnt <= (sec_cnt == SEC_LAST) ? '0 : sec_cnt + 1'b1;
        end else begin
          tick_cnt <= tick_cnt + 1'b1;
        end
      end
    end
  end

  // Pulse high for a fixed count that sits between both width limits.
  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      tick_out <= 1'b0;
      tick_strobe <= 1'b0;
      second_tick <= 1'b0;
    end else if (ce) begin
      tick_out <= (tick_cnt < PULSE_END) && !(align_armed && pps_rise);
      tick_strobe <= (tick_cnt == '0);
      second_tick <= (tick_cnt == '0) && (sec_cnt == '0);
    end
  end

  // Offset from 1 PPS to the next second tick, in coarse cycles of 40 ns.
  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      offset_run <= '0;
      offset_open <= 1'b0;
      second_offset <= '0;
      offset_valid <= 1'b0;
    end else if (ce) begin
      if (pps_rise) begin
        offset_run <= '0;
        offset_open <= 1'b1;
      end else if (offset_open && tick_cnt == '0 && sec_cnt == '0) begin
        second_offset <= offset_run;
        offset_valid <= 1'b1;
        offset_open <= 1'b0;
      end else if (offset_open) begin
        offset_run <= offset_run + 1'b1;
      end
    end
  end

  // Drift: coarse cycles counted, cleared remotely; the clear wins here on purpose.
  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      drift_count <= '0;
    end else if (ce) begin
      if (clr_sync[1]) begin
        drift_count <= '0;
      end else begin
        drift_count <= drift_count + 1'b1;
      end
    end
  end

  logic [TICK_CNT_W-1:0] high_run;
  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      high_run <= '0;
    end else if (ce) begin
      high_run <= tick_out ? high_run + 1'b1 : '0;
    end
  end

  a_pulse_max_width: assert property (@(posedge clk) disable iff (!rst_int_n)
    high_run <= TICK_CNT_W'(PULSE_MAX_CYC))
    else $error("tick pulse too long");
  // Only the single cycle cut by an alignment restart is exempt from the minimum width.
  a_pulse_min_width: assert property (@(posedge clk) disable iff (!rst_int_n)
    ce && $fell(tick_out) && !$past(align_armed && pps_rise)
    |-> $past(high_run) >= TICK_CNT_W'(PULSE_MIN_CYC) - 1)
    else $error("tick pulse too short");
  a_tick_wrap_period: assert property (@(posedge clk) disable iff (!rst_int_n)
    tick_cnt <= TICK_LAST)
    else $error("tick counter beyond period");
  a_second_on_tick: assert property (@(posedge clk) disable iff (!rst_int_n)
    second_tick |-> tick_strobe)
    else $error("second tick off a tick edge");
  a_sec_range: assert property (@(posedge clk) disable iff (!rst_int_n)
    sec_cnt <= SEC_LAST)
    else $error("second counter out of range");
  a_tick_single: assert property (@(posedge clk) disable iff (!rst_int_n)
    ce && tick_strobe ##1 ce |-> !tick_strobe)
    else $error("tick strobe longer than one cycle");
  a_drift_clear: assert property (@(posedge clk) disable iff (!rst_int_n)
    ce && clr_sync[1] ##1 ce |-> drift_count == '0)
    else $error("drift counter not cleared");
  a_drift_count: assert property (@(posedge clk) disable iff (!rst_int_n)
    ce && !clr_sync[1] |=> drift_count == $past(drift_count) + 1'b1 || !$past(ce))
    else $error("drift counter stalled");
  a_align_restart: assert property (@(posedge clk) disable iff (!rst_int_n)
    ce && align_armed && pps_rise |=> tick_cnt == '0 && aligned)
    else $error("alignment did not restart tick");
  a_align_second: assert property (@(posedge clk) disable iff (!rst_int_n)
    ce && align_armed && pps_rise ##1 ce |=> second_tick)
    else $error("aligned restart did not give a second tick");
  a_pulse_start: assert property (@(posedge clk) disable iff (!rst_int_n)
    tick_strobe |-> tick_out)
    else $error("tick pulse not high on tick edge");
  a_exact_wrap: assert property (@(posedge clk) disable iff (!rst_int_n)
    ce && wrap && !(align_armed && pps_rise) |=> tick_cnt == '0)
    else $error("divider did not wrap at period end");
  // Software may read the offset at any time, so once valid it must stay valid.
  a_offset_held: assert property (@(posedge clk) disable iff (!rst_int_n)
    offset_valid |=> offset_valid)
    else $error("offset measurement withdrawn");

  // Main scenarios: second tick, alignment, offset capture, cut pulse, drift clear.
  c_second_tick: cover property (@(posedge clk) disable iff (!rst_int_n) second_tick);
  c_aligned: cover property (@(posedge clk) disable iff (!rst_int_n) $rose(aligned));
  c_offset: cover property (@(posedge clk) disable iff (!rst_int_n) $rose(offset_valid));
  c_align_cut: cover property (@(posedge clk) disable iff (!rst_int_n)
    align_armed && pps_rise && tick_out);
  c_drift_clear: cover property (@(posedge clk) disable iff (!rst_int_n) clr_sync[1]);
endmodule : array_time_tick_generator

// ===== tb_array_time_tick_generator.sv
/* Testbench for the tick generator with a short tick period.
   Assumes tick_gen_pkg and tick_receiver are compiled first. */
`timescale 1ns/1ns
module tb_array_time_tick_generator;
  import tick_gen_pkg::*;
  localparam int unsigned DIV = 200;
  localparam int unsigned SEC = DIV * TICKS_PER_SEC;
  localparam int unsigned D = 1000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic pps = 1'b0;
  logic align_req = 1'b0;
  logic drift_clear = 1'b0;
  logic tick_out;
  logic tick_strobe;
  logic second_tick;
  logic aligned;
  logic offset_valid;
  logic [OFFSET_W-1:0] second_offset;
  logic [DRIFT_W-1:0] drift_count;
  int tick_count;
  int tick_phase;
  int failures = 0;
  int tests_run = 0;
  initial forever #20 clk = ~clk;
  array_time_tick_generator #(.TICK_DIV_P(DIV)) dut (.clk(clk), .rst_n(rst_n), .ce(1'b1),
    .pps(pps), .align_req(align_req), .drift_clear(drift_clear), .tick_out(tick_out),
    .tick_strobe(tick_strobe), .second_tick(second_tick), .aligned(aligned),
    .second_offset(second_offset), .offset_valid(offset_valid), .drift_count(drift_count));
  tick_receiver peer (.clk(clk), .tick_line(tick_out), .tick_count(tick_count),
    .tick_phase(tick_phase));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask : check
  // Outputs are read 1 ns after the edge, once registered values have landed.
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : step
  task automatic wait_strobe(input bit sec, output int n);
    n = 0;
    do begin
      step(1);
      n++;
      if (n > SEC + 5000) begin
        failures++;
        give_verdict();
      end
    end while ((sec ? second_tick : tick_strobe) !== 1'b1);
  endtask : wait_strobe
  task automatic t_period();
    int n;
    int c;
    int w;
    wait_strobe(0, n);
    c = tick_count;
    wait_strobe(0, n);
    check("period", DIV, n);
    check("counted", 1, tick_count - c);
    check("phase", DIV - 1, tick_phase);
    w = 0;
    while (tick_out === 1'b1 && w < DIV) begin
      step(1);
      w++;
    end
    check("width", PULSE_CYC, w);
    check("bounds", 1, w >= PULSE_MIN_CYC && w <= PULSE_MAX_CYC);
  endtask : t_period
  task automatic t_align();
    int n;
    @(posedge clk) align_req <= 1'b1;
    step(4);
    // Dropping the request here keeps a held level from arming a second restart.
    @(posedge clk) {pps, align_req} <= 2'b10;
    wait_strobe(1, n);
    check("latency", 1, n <= ALIGN_TOL_CYC);
    check("strobe", 1, tick_strobe);
    // Releasing costs one edge, so the next second is one cycle nearer.
    @(posedge clk) pps <= 1'b0;
    wait_strobe(1, n);
    check("second", SEC, n + 1);
    check("aligned", 1, aligned);
  endtask : t_align
  task automatic t_offset();
    int n;
    step(SEC - D - 1);
    @(posedge clk) pps <= 1'b1;
    step(5);
    @(posedge clk) pps <= 1'b0;
    wait_strobe(1, n);
    step(1);
    check("valid", 1, offset_valid);
    check("offset", 1, second_offset + 5 >= D && second_offset <= D - 1);
  endtask : t_offset
  task automatic t_drift();
    logic [63:0] a;
    a = drift_count;
    step(50);
    check("drift", 50, drift_count - a);
    @(posedge clk) drift_clear <= 1'b1;
    step(4);
    check("clear", 0, drift_count);
    @(posedge clk) drift_clear <= 1'b0;
    step(10);
    check("restart", 1, drift_count != 0 && drift_count < 13);
  endtask : t_drift
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_period();
    t_align();
    t_offset();
    t_drift();
    give_verdict();
  end
endmodule : tb_array_time_tick_generator

// ===== tick_gen_pkg.sv
/*
 * Shared constants for the array tick generator: clock rate, tick period,
 * pulse width, second alignment and drift counter width.
 * Assumes the design clock is the 25 MHz coarse reference itself.
 */
package tick_gen_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned CLK_NS = 40;
  localparam int unsigned TICK_PERIOD_MS = 48;
  localparam int unsigned TICK_DIV = CLK_HZ / 1000 * TICK_PERIOD_MS;
  localparam int unsigned TICK_CNT_W = 21;
  localparam int unsigned PULSE_MIN_NS = 1000;
  localparam int unsigned PULSE_MAX_PCT = 10;
  localparam int unsigned PULSE_MIN_CYC = (PULSE_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned PULSE_MAX_CYC = TICK_DIV / 100 * PULSE_MAX_PCT;
  localparam int unsigned PULSE_CYC = PULSE_MIN_CYC * 4;
  localparam int unsigned TICKS_PER_SEC = 125;
  localparam int unsigned SEC_CNT_W = 7;
  localparam int unsigned ALIGN_TOL_US = 10;
  localparam int unsigned ALIGN_TOL_CYC = ALIGN_TOL_US * 1000 / CLK_NS;
  localparam int unsigned DRIFT_W = 64;
  localparam int unsigned OFFSET_W = 32;
endpackage : tick_gen_pkg

// ===== tick_receiver.sv
/* Far-side model: an array device that counts tick cycles.
   Assumes tick_line is sampled on the coarse reference clock. */
`timescale 1ns/1ns
module tick_receiver (
  input wire logic clk,
  input wire logic tick_line,
  output int tick_count,
  output int tick_phase
);
  logic last = 1'b0;
  int cnt = 0;
  int phase = 0;
  assign tick_count = cnt;
  assign tick_phase = phase;
  // Every rise is counted, so time kept here never skips a tick.
  always_ff @(posedge clk) begin
    last <= tick_line;
    if (tick_line && !last) begin
      cnt <= cnt + 1;
    end
  end
  // Local phase restarts on each tick, so signals derived from it run at tick multiples.
  always_ff @(posedge clk) begin
    phase <= (tick_line && !last) ? 0 : phase + 1;
  end
endmodule : tick_receiver
